/* tcc_regs.svh */
// timer compare core constants: reset values, codes and field widths
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_DATA_W 8
`define TCC_MAX 8'hFF
`define TCC_BOTTOM 8'h00
`define TCC_RST_COUNT 8'h00
`define TCC_RST_COMPARE 8'h00
`define TCC_RST_OC 1'b0

// wave mode codes
`define TCC_WGM_NORMAL 3'h0
`define TCC_WGM_PHASE_MAX 3'h1
`define TCC_WGM_CTC 3'h2
`define TCC_WGM_FAST_MAX 3'h3
`define TCC_WGM_PHASE_OCA 3'h5
`define TCC_WGM_FAST_OCA 3'h7

// clock source codes
`define TCC_CS_STOP 3'h0
`define TCC_CS_SYS 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7

// prescaler width: divide by 1024 at most
`define TCC_PRE_W 10

// compare output action codes
`define TCC_COM_NONE 2'h0
`define TCC_COM_TOGGLE 2'h1
`define TCC_COM_CLEAR 2'h2
`define TCC_COM_SET 2'h3

`endif

/* tcc_pkg.sv */
// timer compare core types and shared decode functions
package tcc_pkg;
    `include "tcc_regs.svh"

    typedef enum logic [1:0] {
        KIND_NORMAL,
        KIND_CTC,
        KIND_FAST,
        KIND_PHASE
    } tcc_kind_t;

    typedef struct packed {
        logic [2:0] clock_source_select;
        logic [2:0] wave_mode_select;
        logic [1:0] compare_a_action;
        logic [1:0] compare_b_action;
    } tcc_ctrl_t;

    function automatic tcc_kind_t tcc_kind(input logic [2:0] wgm);
        unique case (wgm)
            `TCC_WGM_CTC: tcc_kind = KIND_CTC;
            `TCC_WGM_FAST_MAX, `TCC_WGM_FAST_OCA: tcc_kind = KIND_FAST;
            `TCC_WGM_PHASE_MAX, `TCC_WGM_PHASE_OCA: tcc_kind = KIND_PHASE;
            default: tcc_kind = KIND_NORMAL;
        endcase
    endfunction : tcc_kind

    function automatic logic tcc_pwm(input logic [2:0] wgm);
        tcc_pwm = (tcc_kind(wgm) == KIND_FAST) ||
                  (tcc_kind(wgm) == KIND_PHASE);
    endfunction : tcc_pwm
endpackage : tcc_pkg

/* tcc_tick_gen.sv */
// timer tick source: prescaler taps and synchronised external edge
`timescale 1ns/1ns
`include "tcc_regs.svh"
module tcc_tick_gen
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // selection
    input wire logic [2:0] clock_source_select_i,
    // external count pin
    input wire logic ext_pin_i,
    // tick out
    output logic timer_tick_o
);
    logic [`TCC_PRE_W-1:0] pre_q;
    logic [2:0] sync_q;
    logic level_q;
    logic rise;
    logic fall;

    // prescaler runs free, independent of the selection
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], ext_pin_i};
        end
    end

    // a level counts only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            level_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
        end
    end

    assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !level_q;
    assign fall = (sync_q[1] == sync_q[2]) && !sync_q[2] && level_q;

    always_comb begin
        unique case (clock_source_select_i)
            `TCC_CS_STOP: timer_tick_o = 1'b0;
            `TCC_CS_SYS: timer_tick_o = 1'b1;
            `TCC_CS_DIV8: timer_tick_o = &pre_q[2:0];
            `TCC_CS_DIV64: timer_tick_o = &pre_q[5:0];
            `TCC_CS_DIV256: timer_tick_o = &pre_q[7:0];
            `TCC_CS_DIV1024: timer_tick_o = &pre_q[9:0];
            `TCC_CS_EXT_FALL: timer_tick_o = fall;
            `TCC_CS_EXT_RISE: timer_tick_o = rise;
        endcase
    end
endmodule : tcc_tick_gen

/* tcc_compare_unit.sv */
// one output compare channel: value, buffer, flag and output state
`timescale 1ns/1ns
`include "tcc_regs.svh"
module tcc_compare_unit
    import tcc_pkg::*;
#(
    parameter bit CHANNEL_A = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // mode and action
    input wire logic [2:0] wave_mode_select_i,
    input wire logic [1:0] compare_output_action_i,
    // counter events
    input wire logic [7:0] count_value_i,
    input wire logic timer_tick_i,
    input wire logic block_i,
    input wire logic at_top_i,
    input wire logic counting_up_i,
    // cpu access
    input wire logic compare_wr_i,
    input wire logic [7:0] compare_wdata_i,
    input wire logic force_compare_strobe_i,
    input wire logic flag_clear_i,
    input wire logic int_ack_i,
    // results
    output logic [7:0] compare_value_o,
    output logic [7:0] compare_rdata_o,
    output logic compare_flag_o,
    output logic compare_output_state_o
);
    logic [7:0] buf_q;
    logic pwm;
    logic match;
    logic match_ev;
    logic force_ev;
    logic toggle_ok;
    tcc_kind_t kind;

    assign kind = tcc_kind(wave_mode_select_i);
    assign pwm = tcc_pwm(wave_mode_select_i);
    assign match = (count_value_i == compare_value_o);
    // a count write blocks the next tick's match
    assign match_ev = timer_tick_i && match && !block_i;
    assign force_ev = force_compare_strobe_i && !pwm;
    // toggle in pwm modes only for channel a with top at compare a
    assign toggle_ok = CHANNEL_A && wave_mode_select_i[2];
    // cpu sees the buffer while double buffering
    assign compare_rdata_o = pwm ? buf_q : compare_value_o;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            buf_q <= `TCC_RST_COMPARE;
            compare_value_o <= `TCC_RST_COMPARE;
        end else begin
            if (compare_wr_i) begin
                buf_q <= compare_wdata_i;
            end
            if (compare_wr_i && !pwm) begin
                compare_value_o <= compare_wdata_i;
            // update at top of sequence only
            end else if (pwm && timer_tick_i && at_top_i) begin
                compare_value_o <= buf_q;
            end
        end
    end

    // flag on tick of match; set wins over clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            compare_flag_o <= 1'b0;
        end else if (match_ev) begin
            compare_flag_o <= 1'b1;
        end else if (flag_clear_i || int_ack_i) begin
            compare_flag_o <= 1'b0;
        end
    end

    // reset to zero; mode changes leave state alone
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            compare_output_state_o <= `TCC_RST_OC;
        end else if (match_ev || force_ev) begin
            unique case (compare_output_action_i)
                `TCC_COM_NONE: ;
                `TCC_COM_TOGGLE: begin
                    if (!pwm || toggle_ok) begin
                        compare_output_state_o <= !compare_output_state_o;
                    end
                end
                `TCC_COM_CLEAR: begin
                    compare_output_state_o <= (kind == KIND_PHASE)
                        ? !counting_up_i : 1'b0;
                end
                `TCC_COM_SET: begin
                    compare_output_state_o <= (kind == KIND_PHASE)
                        ? counting_up_i : 1'b1;
                end
            endcase
        end else if (kind == KIND_FAST && timer_tick_i && at_top_i) begin
            // fast pwm: opposite level when wrapping to bottom
            if (compare_output_action_i == `TCC_COM_CLEAR) begin
                compare_output_state_o <= 1'b1;
            end else if (compare_output_action_i == `TCC_COM_SET) begin
                compare_output_state_o <= 1'b0;
            end
        end
    end
endmodule : tcc_compare_unit

/* tcc_core.sv */
// 8-bit timer counter with two output compare channels
`timescale 1ns/1ns
`include "tcc_regs.svh"
// Notes on behaviour
// - each tick clears, increments or decrements the count per mode
// - clock source zero gives no ticks; the count holds
// - cpu may read and write the count at any time
// - a cpu count write beats any clear or count
// - three-bit wave mode: two low bits and one high bit
// - overflow flag set where the mode says; may request interrupt
// - 8-bit comparator matches count against each compare value
// - match sets compare flag on next tick; enabled flag requests interrupt
// - flag clears on interrupt service or software writing one
// - compare values double-buffered in pwm modes only
// - buffered value moves to working value at top only
// - cpu compare access hits buffer when buffered, else working value
// - force strobe updates output like a match outside pwm modes, no flag or clear
// - count write blocks matches on the next tick, even stopped
// - action bits unbuffered; take effect at the next match
// - reset clears each compare output state to zero
// - nonzero action puts output state on pin; direction bit still rules
// - pin override ignores wave mode
// - action zero leaves output state unchanged on match
// - output states survive wave mode changes
// - counter offers clear, top and bottom indications
// - modes 0 normal, 2 clear on match, 3 and 7 fast pwm
// - clock sources: system, four prescaler taps, pin falling or rising
module tcc_core
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // control bits
    input wire tcc_ctrl_t ctrl_i,
    // external count pin
    input wire logic ext_pin_i,
    // cpu count access
    input wire logic count_wr_i,
    input wire logic [7:0] count_wdata_i,
    output logic [7:0] count_value_o,
    // cpu compare access, index 0 is channel a
    input wire logic [1:0] compare_wr_i,
    input wire logic [7:0] compare_a_wdata_i,
    input wire logic [7:0] compare_b_wdata_i,
    output logic [7:0] compare_a_value_o,
    output logic [7:0] compare_b_value_o,
    input wire logic [1:0] force_compare_strobe_i,
    // flags: bit 0 overflow, bit 1 compare a, bit 2 compare b
    input wire logic [2:0] flag_clear_i,
    input wire logic [2:0] int_ack_i,
    input wire logic [2:0] int_enable_i,
    output logic overflow_flag_o,
    output logic compare_a_flag_o,
    output logic compare_b_flag_o,
    output logic [2:0] int_req_o,
    // port pins, index 0 is channel a
    input wire logic [1:0] port_value_i,
    input wire logic [1:0] output_pin_direction_bit_i,
    output logic [1:0] compare_output_state_o,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_o
);
    logic timer_tick;
    logic [2:0] wgm;
    tcc_kind_t kind;
    logic [7:0] top_val;
    logic at_top;
    logic at_bottom;
    logic up_q;
    logic block_q;
    logic ovf_set;
    logic [7:0] count_d;
    logic up_d;
    logic [7:0] cmp_val [2];
    logic [7:0] cmp_rd [2];
    logic [7:0] cmp_wdata [2];
    logic [1:0] cmp_action [2];
    logic [1:0] cmp_flag;

    // wave mode from its single three-bit control field
    assign wgm = ctrl_i.wave_mode_select;
    assign kind = tcc_kind(wgm);

    tcc_tick_gen u_tick (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .clock_source_select_i(ctrl_i.clock_source_select),
        .ext_pin_i(ext_pin_i),
        .timer_tick_o(timer_tick)
    );

    assign top_val = (wgm == `TCC_WGM_CTC || wgm == `TCC_WGM_FAST_OCA ||
                      wgm == `TCC_WGM_PHASE_OCA) ? cmp_val[0] : `TCC_MAX;
    assign at_top = (count_value_o == top_val);
    assign at_bottom = (count_value_o == `TCC_BOTTOM);

    always_comb begin
        count_d = count_value_o;
        up_d = up_q;
        unique case (kind)
            KIND_NORMAL: count_d = count_value_o + 8'h01;
            KIND_CTC, KIND_FAST: begin
                count_d = at_top ? `TCC_BOTTOM : count_value_o + 8'h01;
            end
            KIND_PHASE: begin
                if (at_top) begin
                    up_d = 1'b0;
                end else if (at_bottom) begin
                    up_d = 1'b1;
                end
                count_d = up_d ? count_value_o + 8'h01
                               : count_value_o - 8'h01;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count_value_o <= `TCC_RST_COUNT;
            up_q <= 1'b1;
        end else if (count_wr_i) begin
            count_value_o <= count_wdata_i;
        end else if (timer_tick) begin
            count_value_o <= count_d;
            up_q <= up_d;
        end
    end

    // block lasts until the next tick, even if stopped
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            block_q <= 1'b0;
        end else if (count_wr_i) begin
            block_q <= 1'b1;
        end else if (timer_tick) begin
            block_q <= 1'b0;
        end
    end

    // overflow point: wrap from max, top in fast, bottom in phase
    always_comb begin
        unique case (kind)
            KIND_FAST: ovf_set = at_top;
            KIND_PHASE: ovf_set = at_bottom;
            default: ovf_set = (count_value_o == `TCC_MAX);
        endcase
    end

    // overflow flag; set wins over clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            overflow_flag_o <= 1'b0;
        end else if (timer_tick && !count_wr_i && ovf_set) begin
            overflow_flag_o <= 1'b1;
        end else if (flag_clear_i[0] || int_ack_i[0]) begin
            overflow_flag_o <= 1'b0;
        end
    end

    assign cmp_wdata[0] = compare_a_wdata_i;
    assign cmp_wdata[1] = compare_b_wdata_i;
    assign cmp_action[0] = ctrl_i.compare_a_action;
    assign cmp_action[1] = ctrl_i.compare_b_action;

    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
        tcc_compare_unit #(
            .CHANNEL_A(ch == 0)
        ) u_cmp (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .wave_mode_select_i(wgm),
            .compare_output_action_i(cmp_action[ch]),
            .count_value_i(count_value_o),
            .timer_tick_i(timer_tick && !count_wr_i),
            .block_i(block_q),
            .at_top_i(at_top),
            .counting_up_i(up_q),
            .compare_wr_i(compare_wr_i[ch]),
            .compare_wdata_i(cmp_wdata[ch]),
            .force_compare_strobe_i(force_compare_strobe_i[ch]),
            .flag_clear_i(flag_clear_i[ch+1]),
            .int_ack_i(int_ack_i[ch+1]),
            .compare_value_o(cmp_val[ch]),
            .compare_rdata_o(cmp_rd[ch]),
            .compare_flag_o(cmp_flag[ch]),
            .compare_output_state_o(compare_output_state_o[ch])
        );

        // override on any action bit, mode ignored
        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                pin_o[ch] <= 1'b0;
            end else if (|cmp_action[ch]) begin
                pin_o[ch] <= compare_output_state_o[ch];
            end else begin
                pin_o[ch] <= port_value_i[ch];
            end
        end
    end

    // direction stays with the port bit
    assign pin_oe_o = output_pin_direction_bit_i;

    assign compare_a_value_o = cmp_rd[0];
    assign compare_b_value_o = cmp_rd[1];
    assign compare_a_flag_o = cmp_flag[0];
    assign compare_b_flag_o = cmp_flag[1];

    assign int_req_o = int_enable_i &
                       {compare_b_flag_o, compare_a_flag_o, overflow_flag_o};
endmodule : tcc_core

/* tcc_core_assertions.sv */
// concurrent checks on the timer compare core ports
`timescale 1ns/1ns
module tcc_core_assertions
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // control and cpu side
    input wire tcc_ctrl_t ctrl_i,
    input wire logic count_wr_i,
    input wire logic [7:0] count_wdata_i,
    input wire logic [7:0] count_value_o,
    input wire logic [7:0] compare_a_value_o,
    input wire logic [1:0] force_compare_strobe_i,
    input wire logic [2:0] flag_clear_i,
    input wire logic [2:0] int_enable_i,
    // flags
    input wire logic overflow_flag_o,
    input wire logic compare_a_flag_o,
    input wire logic compare_b_flag_o,
    input wire logic [2:0] int_req_o,
    // pins
    input wire logic [1:0] port_value_i,
    input wire logic [1:0] output_pin_direction_bit_i,
    input wire logic [1:0] compare_output_state_o,
    input wire logic [1:0] pin_o,
    input wire logic [1:0] pin_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic stop;
    logic run1;
    logic no_act;
    // two-cycle qualifiers below tolerate a registered tick source
    assign stop = ctrl_i.clock_source_select == 3'h0;
    assign run1 = ctrl_i.clock_source_select == 3'h1 &&
                  ctrl_i.wave_mode_select == 3'h0;
    assign no_act = ctrl_i.compare_a_action == 2'h0;

    a_oe_dir_follow: assert property (
        pin_oe_o == output_pin_direction_bit_i)
        else $error("pin enable differs from direction bit");
    a_stop_holds: assert property (
        stop && $past(stop) && !count_wr_i |=> $stable(count_value_o))
        else $error("count moved while stopped");
    a_write_wins: assert property (
        count_wr_i |=> count_value_o == $past(count_wdata_i))
        else $error("count write not taken");
    a_normal_increment: assert property (
        run1 && $past(run1) && !count_wr_i
        |=> count_value_o == 8'($past(count_value_o) + 8'h01))
        else $error("normal count did not step by one");
    a_overflow_set: assert property (
        run1 && $past(run1) && !count_wr_i && count_value_o == 8'hff
        |=> overflow_flag_o && count_value_o == 8'h00)
        else $error("wrap did not set overflow");
    a_match_sets_flag: assert property (
        run1 && $past(run1) && !count_wr_i && !$past(count_wr_i) &&
        count_value_o == compare_a_value_o |=> compare_a_flag_o)
        else $error("match did not set compare flag");
    a_int_request: assert property (
        int_req_o == (int_enable_i &
        {compare_b_flag_o, compare_a_flag_o, overflow_flag_o}))
        else $error("interrupt request wrong");
    a_clear_flag: assert property (
        stop && $past(stop) && flag_clear_i[1] |=> !compare_a_flag_o)
        else $error("write one did not clear flag");
    a_force_no_flag: assert property (
        stop && $past(stop) && force_compare_strobe_i[0] &&
        !compare_a_flag_o |=> !compare_a_flag_o)
        else $error("force set the compare flag");
    a_pin_override: assert property (
        !no_act |=> pin_o[0] == $past(compare_output_state_o[0]))
        else $error("pin does not show output state");
    a_pin_port: assert property (
        no_act |=> pin_o[0] == $past(port_value_i[0]))
        else $error("pin does not show port value");
    a_action_zero_hold: assert property (
        no_act |=> $stable(compare_output_state_o[0]))
        else $error("state changed with no action");
    a_reset_clear: assert property (disable iff (1'b0)
        sys_rst_i |=> compare_output_state_o == 2'b00)
        else $error("reset left output state set");
endmodule : tcc_core_assertions

bind tcc_core tcc_core_assertions u_tcc_core_assertions (
    .clk_i, .sys_rst_i, .ctrl_i, .count_wr_i, .count_wdata_i,
    .count_value_o, .compare_a_value_o, .force_compare_strobe_i,
    .flag_clear_i, .int_enable_i, .overflow_flag_o, .compare_a_flag_o,
    .compare_b_flag_o, .int_req_o, .port_value_i,
    .output_pin_direction_bit_i, .compare_output_state_o, .pin_o,
    .pin_oe_o
);

/* tcc_port_model.sv */
// pad model for the two compare output pins
`timescale 1ns/1ns
module tcc_port_model (
    // clock
    input wire logic clk_i,
    // pin drive from the core
    input wire logic [1:0] pin_i,
    input wire logic [1:0] pin_oe_i,
    // level seen on the pads
    output logic [1:0] pad_o
);
    logic [1:0] last_q = 2'b00;
    // undriven pad flips each cycle so no stale level reads as valid
    always_ff @(posedge clk_i) begin
        last_q <= pad_o;
    end
    assign pad_o = (pin_oe_i & pin_i) | (~pin_oe_i & ~last_q);
endmodule : tcc_port_model

/* tcc_core_tb_top.sv */
// self-checking bench for the timer compare core
`timescale 1ns/1ns
module tcc_core_tb_top
    import tcc_pkg::*;
;
    logic clk_i;
    logic sys_rst_i;
    tcc_ctrl_t ctrl_i;
    logic ext_pin_i;
    logic count_wr_i;
    logic [7:0] count_wdata_i;
    logic [7:0] count_value_o;
    logic [1:0] compare_wr_i;
    logic [7:0] compare_a_wdata_i;
    logic [7:0] compare_b_wdata_i;
    logic [7:0] compare_a_value_o;
    logic [7:0] compare_b_value_o;
    logic [1:0] force_compare_strobe_i;
    logic [2:0] flag_clear_i;
    logic [2:0] int_ack_i;
    logic [2:0] int_enable_i;
    logic overflow_flag_o;
    logic compare_a_flag_o;
    logic compare_b_flag_o;
    logic [2:0] int_req_o;
    logic [1:0] port_value_i;
    logic [1:0] output_pin_direction_bit_i;
    logic [1:0] compare_output_state_o;
    logic [1:0] pin_o;
    logic [1:0] pin_oe_o;
    logic [1:0] pad;
    logic [7:0] c0;
    int error_cnt = 0;
    int n_checks = 0;
    int dv[5] = '{1, 8, 64, 256, 1024};
    logic [1:0] acts[6] = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [5:0] expv = 6'h2b;

    tcc_core u_tcc_core (
        .clk_i, .sys_rst_i, .ctrl_i, .ext_pin_i, .count_wr_i,
        .count_wdata_i, .count_value_o, .compare_wr_i, .compare_a_wdata_i,
        .compare_b_wdata_i, .compare_a_value_o, .compare_b_value_o,
        .force_compare_strobe_i, .flag_clear_i, .int_ack_i, .int_enable_i,
        .overflow_flag_o, .compare_a_flag_o, .compare_b_flag_o, .int_req_o,
        .port_value_i, .output_pin_direction_bit_i,
        .compare_output_state_o, .pin_o, .pin_oe_o
    );
    tcc_port_model u_tcc_port_model (
        .clk_i(clk_i), .pin_i(pin_o), .pin_oe_i(pin_oe_o), .pad_o(pad)
    );

    task automatic summarize;
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic stp(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask : stp
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_cnt(input logic [7:0] v);
        count_wr_i = 1'b1;
        count_wdata_i = v;
        stp(1);
        count_wr_i = 1'b0;
    endtask : wr_cnt
    task automatic wr_cmp(input logic [1:0] ch, input logic [7:0] v);
        compare_wr_i = ch;
        compare_a_wdata_i = v;
        compare_b_wdata_i = v + 8'h02;
        stp(1);
        compare_wr_i = 2'b00;
    endtask : wr_cmp

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end
    initial begin
        sys_rst_i = 1'b1;
        ctrl_i = '0;
        {ext_pin_i, count_wr_i, count_wdata_i, compare_wr_i} = '0;
        {compare_a_wdata_i, compare_b_wdata_i} = '0;
        {force_compare_strobe_i, flag_clear_i, int_ack_i} = '0;
        {int_enable_i, output_pin_direction_bit_i} = '0;
        port_value_i = 2'b10;
        stp(3);
        sys_rst_i = 1'b0;
        chk("reset", {count_value_o, overflow_flag_o, compare_a_flag_o,
            compare_b_flag_o, compare_output_state_o, pin_o, 1'b0}, 16'h0);
        int_enable_i = 3'b111;
        wr_cmp(2'b11, 8'h03);
        ctrl_i.clock_source_select = 3'h1;
        wr_cnt(8'h00);
        chk("wr_prio", count_value_o, 16'h0000);
        stp(3);
        chk("walk", {count_value_o, compare_a_flag_o}, 16'h0006);
        stp(3);
        chk("irq", {count_value_o, int_req_o}, {5'h00, 8'h06, 3'h6});
        ctrl_i.clock_source_select = 3'h0;
        stp(2);
        int_ack_i = 3'b100;
        flag_clear_i = 3'b010;
        stp(1);
        {int_ack_i, flag_clear_i} = '0;
        chk("clr", {compare_a_flag_o, compare_b_flag_o}, 16'h0);
        ctrl_i.clock_source_select = 3'h1;
        wr_cnt(8'hfd);
        stp(2);
        chk("ovf0", {count_value_o, overflow_flag_o}, 16'h01fe);
        stp(1);
        chk("ovf1", {count_value_o, overflow_flag_o}, 16'h0001);
        ctrl_i.clock_source_select = 3'h0;
        stp(2);
        flag_clear_i = 3'b001;
        stp(1);
        flag_clear_i = 3'b000;
        chk("ovfclr", overflow_flag_o, 16'h0);
        wr_cnt(8'h03);
        stp(4);
        chk("stopped", count_value_o, 16'h0003);
        ctrl_i.clock_source_select = 3'h1;
        stp(1);
        chk("block", {count_value_o, compare_a_flag_o}, 16'h0008);
        ctrl_i.clock_source_select = 3'h0;
        c0 = count_value_o;
        for (int i = 0; i < 6; i++) begin
            ctrl_i.compare_a_action = acts[i];
            force_compare_strobe_i = 2'b01;
            stp(1);
            force_compare_strobe_i = 2'b00;
            stp(1);
            chk("force", {count_value_o, 3'h0, compare_a_flag_o,
                compare_output_state_o, pin_o}, {c0, 5'h00, expv[i], 1'b1,
                (acts[i] != 2'h0) & expv[i]});
        end
        ctrl_i.compare_b_action = 2'h3;
        force_compare_strobe_i = 2'b10;
        stp(1);
        force_compare_strobe_i = 2'b00;
        // state set up first, direction after
        output_pin_direction_bit_i = 2'b11;
        stp(1);
        chk("pad", {compare_output_state_o, pin_o, pad, pin_oe_o},
            16'h00ff);
        ctrl_i.compare_a_action = 2'h0;
        ctrl_i.compare_b_action = 2'h0;
        ctrl_i.wave_mode_select = 3'h3;
        stp(2);
        chk("modechg", {compare_output_state_o, pin_o}, 16'h000e);
        ctrl_i.compare_a_action = 2'h2;
        stp(2);
        chk("ovr", {compare_output_state_o, pin_o}, 16'h000f);
        ctrl_i.compare_a_action = 2'h0;
        wr_cmp(2'b01, 8'h20);
        chk("rdbuf", compare_a_value_o, 16'h0020);
        chk("rdbuf_b", compare_b_value_o, 16'h0005);
        ctrl_i.clock_source_select = 3'h1;
        wr_cnt(8'h02);
        stp(2);
        chk("dbuf", {count_value_o, compare_a_flag_o}, 16'h0009);
        flag_clear_i = 3'b010;
        stp(1);
        flag_clear_i = 3'b000;
        wr_cnt(8'hfe);
        stp(8);
        chk("load", {count_value_o, overflow_flag_o, compare_a_flag_o},
            16'h001a);
        stp(27);
        chk("newcmp", {count_value_o, overflow_flag_o, compare_a_flag_o},
            16'h0087);
        ctrl_i.wave_mode_select = 3'h2;
        flag_clear_i = 3'b010;
        wr_cmp(2'b01, 8'h03);
        flag_clear_i = 3'b000;
        wr_cnt(8'h00);
        stp(3);
        chk("ctc3", count_value_o, 16'h0003);
        stp(1);
        chk("ctc0", {count_value_o, compare_a_flag_o}, 16'h0001);
        ctrl_i.wave_mode_select = 3'h0;
        for (int i = 0; i < 5; i++) begin
            ctrl_i.clock_source_select = 3'(i + 1);
            stp(1);
            c0 = count_value_o;
            stp(2 * dv[i]);
            chk("tap", 8'(count_value_o - c0), 16'h0002);
        end
        for (int j = 0; j < 2; j++) begin
            ctrl_i.clock_source_select = 3'(7 - j);
            stp(1);
            c0 = count_value_o;
            repeat (3) begin
                ext_pin_i = 1'b1;
                stp(4);
                ext_pin_i = 1'b0;
                stp(4);
            end
            stp(4);
            chk("ext", 8'(count_value_o - c0), 16'h0003);
        end
        ctrl_i.clock_source_select = 3'h1;
        ctrl_i.wave_mode_select = 3'h7;
        wr_cnt(8'h00);
        stp(3);
        chk("fast7top", count_value_o, 16'h0003);
        stp(1);
        chk("fast7wrap", count_value_o, 16'h0000);
        summarize();
    end
endmodule : tcc_core_tb_top
